/* tcd_consts.vh */
`ifndef TCD_CONSTS_VH
`define TCD_CONSTS_VH

// Register offsets
`define TCD_ADDR_IFACE_CLK 8'h01
`define TCD_ADDR_TX_PATH 8'h13
`define TCD_ADDR_CLK_SRC 8'h15
`define TCD_ADDR_PIN2_SRC 8'h16

// Reset values
`define TCD_RST_IFACE_CLK 8'h00
`define TCD_RST_TX_PATH 8'h00
`define TCD_RST_CLK_SRC 8'h00
`define TCD_RST_PIN2_SRC 8'h00

// interface_clock_config fields
`define TCD_CLK_MODE_HI 7
`define TCD_CLK_MODE_LO 5
`define TCD_PIN2_CLK_EN 2
`define TCD_PIN3_CLK_INV 1

// transmit_path_config fields
`define TCD_TX_SAMPLE_EDGE 5
`define TCD_INTERP_HI 1
`define TCD_INTERP_LO 0

// clock_source_config fields
`define TCD_MULT_BYPASS 7
`define TCD_CONV_DIV2 5
`define TCD_ALT_TIMING 4
`define TCD_DIV5_EN 3
`define TCD_MULT_HI 2
`define TCD_MULT_LO 0

// second_pin_source_config fields
`define TCD_PIN2_SRC_SEL 5

// Clock mode codes
`define TCD_MODE_DEFAULT 3'h0
`define TCD_MODE_OPTIONAL 3'h1
`define TCD_MODE_CLONE 3'h2

// Interpolation codes
`define TCD_INTERP_1X 2'h0
`define TCD_INTERP_2X 2'h1
`define TCD_INTERP_4X 2'h2

// Multiplier codes
`define TCD_MULT_1X 3'h0
`define TCD_MULT_2X 3'h1
`define TCD_MULT_4X 3'h2
`define TCD_MULT_8X 3'h3
`define TCD_MULT_16X 3'h4

// Divide-by-five factor
`define TCD_DIV5_FACTOR 19'h00005

`endif

/* tcd_clock_distribution.v */
`timescale 1ns/1ps
`default_nettype none
`include "tcd_consts.vh"

// Behaviour
// - Interleaved modes need two- or four-times interpolation
// - Update clock equals transmit reference times multiplier
// - Parallel transmit clock is update rate over interpolation
// - Interleaved transmit clock is twice the parallel rate, equal to it at one-times interpolation
// - Normal timing: receive clock from receive reference
// - Alternative timing: receive clock from multiplier output
// - Second pin clock: receive reference or update rate
// - Enable clear: no second pin clock except full-duplex
// - Full-duplex: second pin clock, enable bit inverts it; optional mode sends receive sync
// - Third pin clock invert bit inverts third pin
// - Sample-edge bit picks rising or falling latch edge
// - Two-bit field selects one, two or four interpolation
// - Bypass bit removes multiplier from system clock
// - Divider bit halves the receive converter clock
// - Alternate timing bit selects receive path source
// - Divide-by-five bit divides multiplier output by five
// - Three-bit field selects multiplier one to sixteen
// - Source bit routes reference or multiplier to pin
// - Clock mode field resets to zero, default modes
module tcd_clock_distribution (
  input wire clock,
  input wire rst,
  input wire reg_wr_en,
  input wire reg_rd_en,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata,
  input wire full_duplex,
  input wire half_duplex_narrow,
  input wire rx_reference_input,
  input wire tx_reference_input,
  input wire transmit_sync,
  input wire receive_sync,
  input wire first_interface_pin_in,
  output reg first_interface_pin_out,
  output reg first_interface_pin_oe,
  output reg second_interface_pin,
  output reg third_interface_pin,
  output reg converter_update_clock,
  output reg tx_data_clock,
  output reg rx_converter_clock,
  output reg tx_latch_strobe,
  output reg transmit_active,
  output reg interleave_fault
);

  function [4:0] tcd_mult;
    input [2:0] code;
    begin
      case (code)
        `TCD_MULT_1X: tcd_mult = 5'h01;
        `TCD_MULT_2X: tcd_mult = 5'h02;
        `TCD_MULT_4X: tcd_mult = 5'h04;
        `TCD_MULT_8X: tcd_mult = 5'h08;
        `TCD_MULT_16X: tcd_mult = 5'h10;
        default: tcd_mult = 5'h01;
      endcase
    end
  endfunction

  function [2:0] tcd_interp;
    input [1:0] code;
    begin
      case (code)
        `TCD_INTERP_1X: tcd_interp = 3'h1;
        `TCD_INTERP_2X: tcd_interp = 3'h2;
        default: tcd_interp = 3'h4;
      endcase
    end
  endfunction

  // Configuration registers
  reg [7:0] iface_clk_reg;
  reg [7:0] tx_path_reg;
  reg [7:0] clk_src_reg;
  reg [7:0] pin2_src_reg;

  // Reference and direction pin synchroniser stages
  reg txr_s1_reg;
  reg txr_s2_reg;
  reg txr_s3_reg;
  reg rxr_s1_reg;
  reg rxr_s2_reg;
  reg rxr_s3_reg;
  reg pin1_s1_reg;
  reg pin1_s2_reg;

  // Period measurement and clock synthesis state
  reg [15:0] per_cnt_reg;
  reg [15:0] per_reg;
  reg per_seen_reg;
  reg [18:0] acc_reg;
  reg [18:0] acc_next;
  reg upd_clk_reg;
  reg [2:0] tx_cnt_reg;
  reg tx_clk_reg;
  reg rx_half_reg;
  reg rx_clk_reg;

  // Register fields
  wire [2:0] clk_mode = iface_clk_reg[`TCD_CLK_MODE_HI:`TCD_CLK_MODE_LO];
  wire pin2_en = iface_clk_reg[`TCD_PIN2_CLK_EN];
  wire pin3_inv = iface_clk_reg[`TCD_PIN3_CLK_INV];
  wire sample_fall = tx_path_reg[`TCD_TX_SAMPLE_EDGE];
  wire [1:0] interp_code = tx_path_reg[`TCD_INTERP_HI:`TCD_INTERP_LO];
  wire bypass = clk_src_reg[`TCD_MULT_BYPASS];
  wire conv_div2 = clk_src_reg[`TCD_CONV_DIV2];
  wire alt_timing = clk_src_reg[`TCD_ALT_TIMING];
  wire div5_en = clk_src_reg[`TCD_DIV5_EN];
  wire pin2_src = pin2_src_reg[`TCD_PIN2_SRC_SEL];
  wire [2:0] mult_code = clk_src_reg[`TCD_MULT_HI:`TCD_MULT_LO];

  // Mode decode
  wire opt_mode = (clk_mode == `TCD_MODE_OPTIONAL);
  wire clone_mode = !full_duplex && (clk_mode == `TCD_MODE_CLONE);
  wire interleaved = full_duplex || half_duplex_narrow || clone_mode;
  wire hd_transmit = pin1_s2_reg;

  // Edge detectors on synchronised references
  wire tx_rise = txr_s2_reg && !txr_s3_reg;
  wire rx_rise = rxr_s2_reg && !rxr_s3_reg;
  wire rx_fall = !rxr_s2_reg && rxr_s3_reg;

  // Multiplier: half-period tick rate is twice reference times factor
  wire [4:0] mult_f = bypass ? 5'h01 : tcd_mult(mult_code);
  wire [5:0] inc = {mult_f, 1'b0};
  wire [18:0] per_ext = {3'h0, per_reg};
  // Five periods of at most 16 bits fit in 19 bits
  wire [18:0] per_x5 = per_ext * `TCD_DIV5_FACTOR;
  wire [18:0] target = div5_en ? per_x5 : per_ext;
  wire [19:0] sum = {1'b0, acc_reg} + {14'h0000, inc};
  wire half_tick = (per_reg != 16'h0000) && (sum >= {1'b0, target});

  // Transmit clock divider in half-ticks
  wire [2:0] interp_f = tcd_interp(interp_code);
  wire [2:0] tx_div_raw = interleaved ? {1'b0, interp_f[2:1]} : interp_f;
  wire [2:0] tx_div = (tx_div_raw == 3'h0) ? 3'h1 : tx_div_raw;
  wire tx_toggle = half_tick && ((tx_cnt_reg + 3'h1) >= tx_div);

  // Receive path events, halved when the divider is set
  wire rx_ev = alt_timing ? half_tick : (rx_rise || rx_fall);
  wire rx_toggle = rx_ev && (!conv_div2 || rx_half_reg);

  always @* begin
    acc_next = sum[18:0];
    if (half_tick) begin
      acc_next = sum[18:0] - target;
      // Saturate so a stale remainder cannot cause a burst of ticks
      if (acc_next >= target) begin
        acc_next = target - 19'h00001;
      end
    end
  end

  // Register port
  always @(posedge clock) begin
    if (rst) begin
      iface_clk_reg <= `TCD_RST_IFACE_CLK;
      tx_path_reg <= `TCD_RST_TX_PATH;
      clk_src_reg <= `TCD_RST_CLK_SRC;
      pin2_src_reg <= `TCD_RST_PIN2_SRC;
      reg_rdata <= 8'h00;
    end else begin
      if (reg_wr_en) begin
        case (reg_addr)
          `TCD_ADDR_IFACE_CLK: iface_clk_reg <= reg_wdata;
          `TCD_ADDR_TX_PATH: tx_path_reg <= reg_wdata;
          `TCD_ADDR_CLK_SRC: clk_src_reg <= reg_wdata;
          `TCD_ADDR_PIN2_SRC: pin2_src_reg <= reg_wdata;
          default: ;
        endcase
      end
      if (reg_rd_en) begin
        case (reg_addr)
          `TCD_ADDR_IFACE_CLK: reg_rdata <= iface_clk_reg;
          `TCD_ADDR_TX_PATH: reg_rdata <= tx_path_reg;
          `TCD_ADDR_CLK_SRC: reg_rdata <= clk_src_reg;
          `TCD_ADDR_PIN2_SRC: reg_rdata <= pin2_src_reg;
          default: reg_rdata <= 8'h00;
        endcase
      end
    end
  end

  // Pin synchronisers
  always @(posedge clock) begin
    if (rst) begin
      txr_s1_reg <= 1'b0;
      txr_s2_reg <= 1'b0;
      txr_s3_reg <= 1'b0;
      rxr_s1_reg <= 1'b0;
      rxr_s2_reg <= 1'b0;
      rxr_s3_reg <= 1'b0;
      pin1_s1_reg <= 1'b0;
      pin1_s2_reg <= 1'b0;
    end else begin
      txr_s1_reg <= tx_reference_input;
      txr_s2_reg <= txr_s1_reg;
      txr_s3_reg <= txr_s2_reg;
      rxr_s1_reg <= rx_reference_input;
      rxr_s2_reg <= rxr_s1_reg;
      rxr_s3_reg <= rxr_s2_reg;
      pin1_s1_reg <= first_interface_pin_in;
      pin1_s2_reg <= pin1_s1_reg;
    end
  end

  // Reference period measurement and clock synthesis
  always @(posedge clock) begin
    if (rst) begin
      per_cnt_reg <= 16'h0000;
      per_reg <= 16'h0000;
      per_seen_reg <= 1'b0;
      acc_reg <= 19'h00000;
      upd_clk_reg <= 1'b0;
      tx_cnt_reg <= 3'h0;
      tx_clk_reg <= 1'b0;
      rx_half_reg <= 1'b0;
      rx_clk_reg <= 1'b0;
    end else begin
      if (tx_rise) begin
        // The first edge after reset only starts the count
        per_seen_reg <= 1'b1;
        if (per_seen_reg) begin
          per_reg <= per_cnt_reg + 16'h0001;
        end
        per_cnt_reg <= 16'h0000;
      end else if (per_cnt_reg != 16'hFFFF) begin
        per_cnt_reg <= per_cnt_reg + 16'h0001;
      end
      acc_reg <= acc_next;
      if (half_tick) begin
        upd_clk_reg <= !upd_clk_reg;
        if (tx_toggle) begin
          tx_cnt_reg <= 3'h0;
          tx_clk_reg <= !tx_clk_reg;
        end else begin
          tx_cnt_reg <= tx_cnt_reg + 3'h1;
        end
      end
      if (rx_ev) begin
        rx_half_reg <= !rx_half_reg;
      end
      if (rx_toggle) begin
        rx_clk_reg <= !rx_clk_reg;
      end
    end
  end

  // Converter clocks and status outputs
  always @(posedge clock) begin
    if (rst) begin
      converter_update_clock <= 1'b0;
      tx_data_clock <= 1'b0;
      rx_converter_clock <= 1'b0;
      tx_latch_strobe <= 1'b0;
      transmit_active <= 1'b0;
      interleave_fault <= 1'b0;
    end else begin
      converter_update_clock <= upd_clk_reg;
      tx_data_clock <= tx_clk_reg;
      rx_converter_clock <= rx_clk_reg;
      transmit_active <= full_duplex || hd_transmit;
      interleave_fault <= interleaved && (interp_code == `TCD_INTERP_1X);
      tx_latch_strobe <= half_tick && tx_toggle && (tx_clk_reg == sample_fall);
    end
  end

  // Interface pin formatter
  always @(posedge clock) begin
    if (rst) begin
      first_interface_pin_out <= 1'b0;
      first_interface_pin_oe <= 1'b0;
      second_interface_pin <= 1'b0;
      third_interface_pin <= 1'b0;
    end else begin
      first_interface_pin_oe <= full_duplex;
      first_interface_pin_out <= full_duplex && transmit_sync;
      if (full_duplex) begin
        if (opt_mode) begin
          second_interface_pin <= receive_sync;
        end else begin
          second_interface_pin <= rxr_s2_reg ^ pin2_en;
        end
      end else if (pin2_en) begin
        second_interface_pin <= pin2_src ? upd_clk_reg : rxr_s2_reg;
      end else begin
        second_interface_pin <= 1'b0;
      end
      if (full_duplex || hd_transmit) begin
        third_interface_pin <= tx_clk_reg ^ pin3_inv;
      end else begin
        third_interface_pin <= rx_clk_reg ^ pin3_inv;
      end
    end
  end

endmodule
`default_nettype wire

/* tcd_checker_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module tcd_checker (
  input wire logic clock,
  input wire logic rst,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_rdata,
  input wire logic full_duplex,
  input wire logic first_interface_pin_oe,
  input wire logic first_interface_pin_out,
  input wire logic transmit_sync,
  input wire logic transmit_active,
  input wire logic tx_latch_strobe
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  fd_pin_drive_a: assert property (full_duplex [*2] |-> first_interface_pin_oe)
    else $error("first pin not driven");
  hd_pin_input_a: assert property (!full_duplex [*2] |-> !first_interface_pin_oe)
    else $error("first pin driven");
  hd_pin_low_a: assert property (!full_duplex [*2] |-> !first_interface_pin_out)
    else $error("first pin out high");
  fd_active_a: assert property (full_duplex [*2] |-> transmit_active)
    else $error("transmit inactive");
  fd_sync_copy_a: assert property (full_duplex |=> first_interface_pin_out == $past(transmit_sync))
    else $error("first pin does not follow transmit sync");
  read_hold_a: assert property (!reg_rd_en |=> $stable(reg_rdata))
    else $error("read data moved");
  unmapped_zero_a: assert property (reg_rd_en && !(reg_addr inside {8'h01, 8'h13, 8'h15, 8'h16})
    |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  strobe_pulse_a: assert property (tx_latch_strobe |=> !tx_latch_strobe)
    else $error("strobe too long");
  reset_clear_a: assert property ($fell(rst) |-> reg_rdata == 8'h00 && !first_interface_pin_oe)
    else $error("not clear after reset");
endmodule
bind tcd_clock_distribution tcd_checker u_tcd_checker (.clock(clock), .rst(rst), .reg_rd_en(reg_rd_en),
  .reg_addr(reg_addr), .reg_rdata(reg_rdata), .full_duplex(full_duplex),
  .first_interface_pin_oe(first_interface_pin_oe), .first_interface_pin_out(first_interface_pin_out),
  .transmit_active(transmit_active), .tx_latch_strobe(tx_latch_strobe), .transmit_sync(transmit_sync));
`default_nettype wire

/* tcd_baseband_model.sv */
`timescale 1ns/1ps
`default_nettype none
module tcd_baseband_model (
  input wire logic hd_tx,
  output var logic rx_ref,
  output var logic tx_ref,
  output wire logic tx_sync,
  output wire logic rx_sync,
  output wire logic dir_pin
);
  initial begin
    tx_ref = 1'b0;
    #7;
    forever #200 tx_ref = ~tx_ref;
  end
  initial begin
    rx_ref = 1'b0;
    forever #250 rx_ref = ~rx_ref;
  end
  assign tx_sync = ~tx_ref;
  assign rx_sync = tx_ref;
  assign dir_pin = hd_tx;
endmodule
`default_nettype wire

/* test_tcd_clock_distribution.sv */
`timescale 1ns/1ps
`default_nettype none
module test_tcd_clock_distribution;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic fd = 1'b0;
  logic hd = 1'b1;
  logic hdn = 1'b0;
  wire logic [7:0] rdata;
  wire logic rx_ref, tx_ref, tx_sync, rx_sync, dir_pin, p1o, p1e, pin2, pin3, upd, txc, rxc, stb, act, flt;
  int bad_count = 0;
  int n_compared = 0;
  int n[6];
  int eq;
  int eq2;
  always #12.5 clock = ~clock;
  tcd_baseband_model u_tcd_baseband_model (.hd_tx(hd), .rx_ref(rx_ref), .tx_ref(tx_ref),
    .tx_sync(tx_sync), .rx_sync(rx_sync), .dir_pin(dir_pin));
  tcd_clock_distribution u_tcd_clock_distribution (.clock(clock), .rst(rst), .reg_wr_en(wr_en),
    .reg_rd_en(rd_en), .reg_addr(addr), .reg_wdata(wdata), .reg_rdata(rdata), .full_duplex(fd),
    .half_duplex_narrow(hdn), .rx_reference_input(rx_ref), .tx_reference_input(tx_ref),
    .transmit_sync(tx_sync), .receive_sync(rx_sync), .first_interface_pin_in(dir_pin),
    .first_interface_pin_out(p1o), .first_interface_pin_oe(p1e), .second_interface_pin(pin2),
    .third_interface_pin(pin3), .converter_update_clock(upd), .tx_data_clock(txc),
    .rx_converter_clock(rxc), .tx_latch_strobe(stb), .transmit_active(act), .interleave_fault(flt));
  task automatic chk(input int got, input int exp, input int tol);
    n_compared++;
    if (got < exp - tol || got > exp + tol) begin
      bad_count++;
      $display("[FAIL] %0t count %0d exp %0d", $time, got, exp);
    end
  endtask
  task automatic chk8(input logic [7:0] exp);
    n_compared++;
    if (rdata !== exp) begin
      bad_count++;
      $display("[FAIL] %0t read %h exp %h", $time, rdata, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    wr_en <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clock);
    wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clock);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge clock);
    rd_en <= 1'b0;
    #1;
    chk8(e);
  endtask
  task automatic meas;
    logic [5:0] p;
    logic [5:0] c;
    repeat (64) @(posedge clock);
    n = '{default: 0};
    eq = 0;
    eq2 = 0;
    p = 6'h00;
    repeat (400) begin
      @(posedge clock);
      #1;
      c = {upd, txc, rxc, pin2, pin3, stb};
      for (int i = 0; i < 6; i++) n[i] += (c[i] === 1'b1 && p[i] === 1'b0) ? 1 : 0;
      eq += (pin3 === txc) ? 1 : 0;
      eq2 += (pin2 === rx_ref) ? 1 : 0;
      p = c;
    end
  endtask
  task automatic t_regs;
    rd(8'h01, 8'h00);
    rd(8'h13, 8'h00);
    rd(8'h15, 8'h00);
    rd(8'h16, 8'h00);
    wr(8'h16, 8'hA5);
    rd(8'h16, 8'hA5);
    rd(8'h02, 8'h00);
    wr(8'h16, 8'h00);
    $display("regs done");
  endtask
  task automatic t_mult;
    for (int k = 0; k < 4; k++) begin
      wr(8'h15, 8'(k));
      meas();
      chk(n[5], 25 << k, 1);
    end
    wr(8'h15, 8'h0B);
    meas();
    chk(n[5], 40, 1);
    wr(8'h15, 8'h83);
    meas();
    chk(n[5], 25, 1);
    $display("mult done");
  endtask
  task automatic t_tx;
    wr(8'h15, 8'h00);
    wr(8'h13, 8'h01);
    meas();
    chk(n[4], 12, 1);
    chk(n[0], 12, 1);
    chk(eq, 400, 50);
    wr(8'h01, 8'h02);
    meas();
    chk(eq, 0, 50);
    wr(8'h01, 8'h00);
    wr(8'h13, 8'h21);
    meas();
    chk(n[0], 12, 1);
    wr(8'h13, 8'h02);
    meas();
    chk(n[4], 6, 1);
    wr(8'h13, 8'h01);
    fd <= 1'b1;
    meas();
    chk(n[4], 25, 1);
    chk(n[1], 25, 1);
    chk(n[2], 20, 1);
    chk(eq2, 320, 8);
    wr(8'h01, 8'h04);
    meas();
    chk(eq2, 80, 8);
    wr(8'h01, 8'h00);
    chk((flt === 1'b0) ? 1 : 0, 1, 0);
    wr(8'h13, 8'h00);
    meas();
    chk((flt === 1'b1) ? 1 : 0, 1, 0);
    wr(8'h13, 8'h01);
    fd <= 1'b0;
    $display("tx done");
  endtask
  task automatic t_rx;
    wr(8'h15, 8'h00);
    meas();
    chk(n[3], 20, 1);
    wr(8'h15, 8'h20);
    meas();
    chk(n[3], 10, 1);
    wr(8'h15, 8'h10);
    meas();
    chk(n[3], 25, 1);
    wr(8'h15, 8'h30);
    meas();
    chk(n[3], 12, 1);
    wr(8'h15, 8'h00);
    $display("rx done");
  endtask
  task automatic t_pin2;
    meas();
    chk(n[2], 0, 0);
    wr(8'h01, 8'h04);
    meas();
    chk(n[2], 20, 1);
    wr(8'h16, 8'h20);
    meas();
    chk(n[2], 25, 1);
    $display("pin2 done");
  endtask
  task automatic t_modes;
    wr(8'h16, 8'h00);
    wr(8'h01, 8'h00);
    hd <= 1'b0;
    meas();
    chk(n[1], 20, 1);
    chk((act === 1'b0 && p1e === 1'b0) ? 1 : 0, 1, 0);
    @(posedge clock);
    hd <= 1'b1;
    hdn <= 1'b1;
    meas();
    chk(n[4], 25, 1);
    chk(n[1], 25, 1);
    @(posedge clock);
    hdn <= 1'b0;
    wr(8'h01, 8'h40);
    meas();
    chk(n[4], 25, 1);
    wr(8'h01, 8'h20);
    fd <= 1'b1;
    meas();
    chk(n[2], 25, 1);
    @(posedge clock);
    fd <= 1'b0;
    wr(8'h01, 8'h00);
    $display("modes done");
  endtask
  task automatic print_verdict;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    t_regs();
    t_mult();
    t_tx();
    t_rx();
    t_pin2();
    t_modes();
    print_verdict();
  end
  initial begin
    #1000000;
    bad_count++;
    $display("[FAIL] %0t watchdog", $time);
    print_verdict();
  end
endmodule
`default_nettype wire
